// ===== hw/flash_port_pkg.sv
// package: constants, states and carriers for the flash port mode router
// ----------------------------------------
// Summary of operation
// ----------------------------------------
// Summary of operation
// (RULE1) program pin alone asserted connects embedded flash to tester port
// (RULE2) tester mode turns scan pins into tester port signals
// (RULE3) program pin high holds controller reset low
// (RULE4) tester mode disables all flash write protection including boot block
// (RULE5) program pin release reconnects flash to controller code path
// (RULE6) program pin release returns flash to array read state
// (RULE7) program pin release lets the controller run again
// (RULE8) program pin release re-enables flash write protection
// (RULE9) external select low routes code fetches to external flash port
// (RULE10) external mode turns scan pins into external flash port signals
// (RULE11) external mode holds embedded flash in reset throughout
// (RULE12) external port issues only instruction reads, never writes or erases
// (RULE13) high address on eight pins, low address and data share eight pins
// (RULE14) address valid before latch strobe falls, read strobe low after that
// (RULE15) instruction byte sampled while read strobe low, held until it rises
// (RULE16) tester write: latch pulse, write low after latch falls, data held
// (RULE17) tester read: tester floats address pins by read strobe fall
// (RULE18) device drives read data while tester read low, releases after
// (RULE19) system should not reset device while flash is busy
// (RULE20) low address latched from muxed pins by tester latch strobe
// (RULE21) tester strobes active low: write strobe writes, read strobe reads
// (RULE22) both selects asserted together enters neither mode
package flash_port_pkg;
    // ----------------------------------------
    // widths and timing
    // ----------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 100;
    // latch-high and latch-low setup phases of an external read; read low uses the access time
    localparam int EXT_PHASE_NS = 100;
    localparam int EXT_PHASE_CYC = (EXT_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS > 0 ?
        (EXT_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS : 1;
    // access time of external memory, read strobe low at least this long
    localparam int EXT_ACCESS_NS = 200;
    localparam int EXT_ACCESS_CYC = (EXT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PHASE_CNT = 4'(EXT_PHASE_CYC);
    localparam logic [3:0] ACCESS_CNT = 4'(EXT_ACCESS_CYC);
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_TESTER, MODE_EXTCODE} mode_e;
    typedef enum logic [2:0] {EXT_IDLE, EXT_ALE, EXT_SETUP, EXT_READ, EXT_DONE} ext_state_e;

    // embedded flash interface
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
        logic reset;
        logic wp_disable;
        logic read_array;
    } flash_req_s;

    // controller code fetch request and answer
    typedef struct packed {
        logic [15:0] addr;
        logic req;
    } fetch_req_s;
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } fetch_rsp_s;

    function automatic mode_e decode_mode(input logic prog_sel, input logic ext_sel_n);
        if (prog_sel && ext_sel_n) begin
            return MODE_TESTER;
        end else if (!prog_sel && !ext_sel_n) begin
            return MODE_EXTCODE;
        end
        return MODE_NORMAL;
    endfunction
endpackage

// ===== hw/low_addr_latch.sv
// module: latch for a low address byte taken off a multiplexed bus
`timescale 1ns/10ps
module low_addr_latch (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic strobe_i,
    input wire logic [7:0] bus_i,
    output logic [7:0] addr_o
);
    logic [7:0] addr_ff;

    // the byte is loaded on each clock while the strobe is high and held after its fall
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_ff <= flash_port_pkg::DATA_RESET;
        end else if (strobe_i) begin
            addr_ff <= bus_i; // RULE20
        end
    end

    assign addr_o = addr_ff;
endmodule

// ===== hw/flash_port_mode_mux.sv
// module: mode router between embedded flash, tester port and external code port
`timescale 1ns/10ps
module flash_port_mode_mux (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic tester_program_select_i,
    input wire logic external_code_select_n_i,
    // scan pins: 12 outputs, 8 inputs, each split into in/out/enable (enable low drives)
    input wire logic [11:0] scan_out_pin_i,
    output logic [11:0] scan_out_pin_o,
    output logic [11:0] scan_out_pin_oe_n_o,
    input wire logic [7:0] scan_in_pin_i,
    output logic [7:0] scan_in_pin_o,
    output logic [7:0] scan_in_pin_oe_n_o,
    // scan engine side when no port mode owns the pins
    input wire logic [11:0] scan_drive_i,
    output logic [7:0] scan_sense_o,
    // embedded flash
    output flash_port_pkg::flash_req_s flash_req_o,
    input wire logic [7:0] flash_rdata_i,
    // controller
    input wire flash_port_pkg::fetch_req_s fetch_req_i,
    output flash_port_pkg::fetch_rsp_s fetch_rsp_o,
    input wire logic [15:0] ctrl_flash_addr_i,
    output logic ctrl_reset_n_o,
    output flash_port_pkg::mode_e mode_o
);
    flash_port_pkg::mode_e mode_ff;
    flash_port_pkg::mode_e nxt_mode;
    flash_port_pkg::ext_state_e ext_ff;
    flash_port_pkg::ext_state_e nxt_ext;
    logic [3:0] cnt_ff;
    logic [15:0] ext_addr_ff;
    logic [7:0] ext_data_ff;
    logic fetch_valid_ff;
    logic [11:0] so_o_ff, so_oe_n_ff;
    logic [7:0] si_o_ff, si_oe_n_ff, sense_ff;
    flash_port_pkg::flash_req_s flash_ff;
    logic ctrl_rst_n_ff;
    logic rd_n_ff;
    logic [15:0] nxt_ext_addr;
    logic wr_pend_ff;
    logic [7:0] tester_low;
    logic [15:0] tester_addr;
    logic [7:0] tester_ad;

    // ----------------------------------------
    // pin aliases in tester port mode
    // ----------------------------------------
    assign tester_ad = {scan_out_pin_i[8], scan_out_pin_i[9], scan_out_pin_i[10], scan_out_pin_i[11],
                        scan_in_pin_i[0], scan_in_pin_i[1], scan_in_pin_i[2], scan_in_pin_i[3]};
    wire tester_addr_latch = scan_in_pin_i[4];
    wire tester_read_n = scan_in_pin_i[5];
    wire tester_write_n = scan_in_pin_i[6];
    wire [7:0] tester_addr_high = {scan_out_pin_i[0], scan_out_pin_i[1], scan_out_pin_i[2], scan_out_pin_i[3],
                                   scan_out_pin_i[4], scan_out_pin_i[5], scan_out_pin_i[6], scan_out_pin_i[7]};

    low_addr_latch u_low_latch (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .strobe_i(tester_addr_latch && mode_ff == flash_port_pkg::MODE_TESTER),
        .bus_i(tester_ad),
        .addr_o(tester_low)
    );
    assign tester_addr = {tester_addr_high, tester_low};

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    assign nxt_mode = flash_port_pkg::decode_mode(tester_program_select_i, external_code_select_n_i); // RULE22

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_ff <= flash_port_pkg::MODE_NORMAL;
        end else begin
            mode_ff <= nxt_mode; // RULE1 RULE9
        end
    end

    // controller held in reset for as long as the program pin is high
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_rst_n_ff <= 1'b0;
        end else begin
            ctrl_rst_n_ff <= !tester_program_select_i; // RULE3 RULE7
        end
    end

    // ----------------------------------------
    // tester strobes
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_n_ff <= 1'b1;
            wr_pend_ff <= 1'b0;
        end else begin
            rd_n_ff <= tester_read_n;
            // the write lands on the strobe's rising edge, when data is settled
            wr_pend_ff <= !tester_write_n && mode_ff == flash_port_pkg::MODE_TESTER; // RULE21
        end
    end

    // ----------------------------------------
    // embedded flash connection
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flash_ff <= '0;
        end else begin
            flash_ff <= '0;
            case (mode_ff)
                flash_port_pkg::MODE_TESTER: begin
                    flash_ff.addr <= tester_addr; // RULE1
                    flash_ff.wdata <= tester_ad;
                    flash_ff.rd <= !tester_read_n; // RULE21
                    flash_ff.wr <= wr_pend_ff && tester_write_n; // RULE21
                    flash_ff.wp_disable <= 1'b1; // RULE4
                end
                flash_port_pkg::MODE_EXTCODE: begin
                    flash_ff.reset <= 1'b1; // RULE11
                end
                default: begin
                    flash_ff.addr <= ctrl_flash_addr_i; // RULE5
                end
            endcase
            if (mode_ff == flash_port_pkg::MODE_TESTER && nxt_mode != flash_port_pkg::MODE_TESTER) begin
                flash_ff.read_array <= 1'b1; // RULE6
                flash_ff.wp_disable <= 1'b0; // RULE8
            end
        end
    end

    // ----------------------------------------
    // external code read sequencer
    // ----------------------------------------
    always_comb begin
        nxt_ext = ext_ff;
        case (ext_ff)
            flash_port_pkg::EXT_IDLE: begin
                if (mode_ff == flash_port_pkg::MODE_EXTCODE && fetch_req_i.req) begin
                    nxt_ext = flash_port_pkg::EXT_ALE;
                end
            end
            flash_port_pkg::EXT_ALE: begin
                if (cnt_ff == 4'h0) nxt_ext = flash_port_pkg::EXT_SETUP;
            end
            flash_port_pkg::EXT_SETUP: begin
                if (cnt_ff == 4'h0) nxt_ext = flash_port_pkg::EXT_READ;
            end
            flash_port_pkg::EXT_READ: begin
                if (cnt_ff == 4'h0) nxt_ext = flash_port_pkg::EXT_DONE;
            end
            flash_port_pkg::EXT_DONE: nxt_ext = flash_port_pkg::EXT_IDLE;
            default: nxt_ext = flash_port_pkg::EXT_IDLE;
        endcase
        if (mode_ff != flash_port_pkg::MODE_EXTCODE) nxt_ext = flash_port_pkg::EXT_IDLE;
    end

    // the address goes out with the latch pulse, so it is settled before the latch falls
    assign nxt_ext_addr = (ext_ff == flash_port_pkg::EXT_IDLE && nxt_ext == flash_port_pkg::EXT_ALE) ?
        fetch_req_i.addr : ext_addr_ff;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ext_ff <= flash_port_pkg::EXT_IDLE;
            cnt_ff <= 4'h0;
            ext_addr_ff <= 16'h0000;
        end else begin
            ext_ff <= nxt_ext;
            if (nxt_ext != ext_ff) begin
                cnt_ff <= nxt_ext == flash_port_pkg::EXT_READ ? flash_port_pkg::ACCESS_CNT - 4'h1
                                                             : flash_port_pkg::PHASE_CNT - 4'h1;
            end else if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
            ext_addr_ff <= nxt_ext_addr;
        end
    end

    // sample on the last read-low cycle; memory holds data until strobe rises
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ext_data_ff <= flash_port_pkg::DATA_RESET;
            fetch_valid_ff <= 1'b0;
        end else begin
            fetch_valid_ff <= 1'b0;
            if (ext_ff == flash_port_pkg::EXT_READ && cnt_ff == 4'h0) begin
                ext_data_ff <= {scan_out_pin_i[8], scan_out_pin_i[9], scan_out_pin_i[10], scan_out_pin_i[11],
                                scan_in_pin_i[0], scan_in_pin_i[1], scan_in_pin_i[2], scan_in_pin_i[3]}; // RULE15
                fetch_valid_ff <= 1'b1;
            end else if (mode_ff == flash_port_pkg::MODE_NORMAL && fetch_req_i.req &&
                         flash_ff.addr == fetch_req_i.addr) begin
                // the flash answers for the address registered one edge earlier
                ext_data_ff <= flash_rdata_i;
                fetch_valid_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // scan pin multiplexing
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            so_o_ff <= 12'h000;
            so_oe_n_ff <= 12'hfff;
            si_o_ff <= 8'h00;
            si_oe_n_ff <= 8'hff;
            sense_ff <= 8'h00;
        end else begin
            sense_ff <= 8'h00;
            si_o_ff <= 8'h00;
            case (mode_ff)
                flash_port_pkg::MODE_TESTER: begin
                    // all pins are tester inputs except data during reads
                    so_o_ff <= {flash_rdata_i[4], flash_rdata_i[5], flash_rdata_i[6], flash_rdata_i[7], 8'h00};
                    si_o_ff <= {4'h0, flash_rdata_i[0], flash_rdata_i[1], flash_rdata_i[2], flash_rdata_i[3]};
                    so_oe_n_ff <= {{4{rd_n_ff | tester_read_n}}, 8'hff}; // RULE2 RULE18
                    si_oe_n_ff <= {4'hf, {4{rd_n_ff | tester_read_n}}}; // RULE18
                end
                flash_port_pkg::MODE_EXTCODE: begin
                    // the latch and read strobes are driven, never the write strobe
                    so_o_ff[7:0] <= {nxt_ext_addr[8], nxt_ext_addr[9], nxt_ext_addr[10], nxt_ext_addr[11],
                                     nxt_ext_addr[12], nxt_ext_addr[13], nxt_ext_addr[14],
                                     nxt_ext_addr[15]}; // RULE13
                    so_o_ff[11:8] <= {nxt_ext_addr[4], nxt_ext_addr[5], nxt_ext_addr[6], nxt_ext_addr[7]};
                    si_o_ff[3:0] <= {nxt_ext_addr[0], nxt_ext_addr[1], nxt_ext_addr[2], nxt_ext_addr[3]};
                    si_o_ff[4] <= nxt_ext == flash_port_pkg::EXT_ALE; // RULE14
                    si_o_ff[5] <= nxt_ext != flash_port_pkg::EXT_READ; // RULE12 RULE14
                    so_oe_n_ff[7:0] <= 8'h00; // RULE10
                    // muxed low address pins float once the read strobe is low; high address stays driven
                    so_oe_n_ff[11:8] <= {4{nxt_ext == flash_port_pkg::EXT_READ}};
                    si_oe_n_ff <= {2'b11, 2'b00, {4{nxt_ext == flash_port_pkg::EXT_READ}}};
                end
                default: begin
                    so_o_ff <= scan_drive_i;
                    so_oe_n_ff <= 12'h000;
                    si_oe_n_ff <= 8'hff;
                    sense_ff <= scan_in_pin_i;
                end
            endcase
        end
    end

    assign scan_out_pin_o = so_o_ff;
    assign scan_out_pin_oe_n_o = so_oe_n_ff;
    assign scan_in_pin_o = si_o_ff;
    assign scan_in_pin_oe_n_o = si_oe_n_ff;
    assign scan_sense_o = sense_ff;
    assign flash_req_o = flash_ff;
    assign fetch_rsp_o = '{data: ext_data_ff, valid: fetch_valid_ff};
    assign ctrl_reset_n_o = ctrl_rst_n_ff;
    assign mode_o = mode_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    ctrl_reset_hold_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
        tester_program_select_i |=> !ctrl_reset_n_o) else $error("controller not held in reset");
    ctrl_release_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE7
        !tester_program_select_i |=> ctrl_reset_n_o) else $error("controller reset not released");
    both_selects_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE22
        (tester_program_select_i && !external_code_select_n_i) |=> mode_o == flash_port_pkg::MODE_NORMAL)
        else $error("mode entered with both selects");
    ext_flash_reset_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE11
        mode_o == flash_port_pkg::MODE_EXTCODE |=> flash_req_o.reset) else $error("flash not in reset");
    wp_disable_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
        (mode_o == flash_port_pkg::MODE_TESTER && tester_program_select_i && external_code_select_n_i)
        |=> flash_req_o.wp_disable) else $error("protection left on");
    read_array_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
        (mode_o == flash_port_pkg::MODE_TESTER && !tester_program_select_i) |=> flash_req_o.read_array)
        else $error("no return to array read");
    ext_strobe_order_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE14
        $fell(scan_in_pin_o[5]) |-> !scan_in_pin_o[4] && !$past(scan_in_pin_o[4]))
        else $error("read strobe low before latch fell");
    ext_addr_hold_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE14
        $fell(scan_in_pin_o[4]) |-> $stable(scan_out_pin_o) && $stable(scan_in_pin_o[3:0]))
        else $error("address moved at latch fall");
    tester_release_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE18
        (mode_o == flash_port_pkg::MODE_TESTER && tester_read_n) |=> scan_in_pin_oe_n_o[0])
        else $error("tester data bus not released");
    wp_reenable_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
        mode_o == flash_port_pkg::MODE_NORMAL |=> !flash_req_o.wp_disable) else $error("protection not restored");
endmodule

// ===== testbench/ext_rom_model.sv
// model: external code memory hanging on the shared scan pins
`timescale 1ns/10ps
module ext_rom_model (
    input wire logic active_i,
    input wire logic slow_i,
    input wire logic [11:0] pin_out_i,
    input wire logic [7:0] pin_in_i,
    output logic drive_en_o,
    output logic [7:0] drive_o,
    output logic [15:0] addr_o,
    output int err_cnt_o
);
    logic [7:0] mux_in;
    logic [7:0] val;
    assign mux_in = {pin_out_i[8], pin_out_i[9], pin_out_i[10], pin_out_i[11],
                     pin_in_i[0], pin_in_i[1], pin_in_i[2], pin_in_i[3]};
    initial begin
        drive_en_o = 1'b0;
        drive_o = 8'h00;
        addr_o = 16'h0000;
        err_cnt_o = 0;
    end
    // low byte is held here, outside the device, from the latch fall
    always @(negedge pin_in_i[4]) begin
        if (active_i) begin
            addr_o = {pin_out_i[0], pin_out_i[1], pin_out_i[2], pin_out_i[3],
                      pin_out_i[4], pin_out_i[5], pin_out_i[6], pin_out_i[7], mux_in};
            if (pin_in_i[5] !== 1'b1) err_cnt_o++;
        end
    end
    // a slow part shows a wrong byte first, so an early sample is caught
    always @(negedge pin_in_i[5]) begin
        if (active_i) begin
            if (pin_in_i[4] !== 1'b0) err_cnt_o++;
            val = addr_o[15:8] + addr_o[7:0] + 8'h33;
            drive_o = ~val;
            drive_en_o = 1'b1;
            #(slow_i ? 150 : 20);
            drive_o = val;
        end
    end
    always @(posedge pin_in_i[5]) begin
        #5 drive_en_o = 1'b0;
    end
endmodule

// ===== testbench/tb.sv
// testbench: mode routing of the flash ports, tester and external code traffic
`timescale 1ns/10ps
module tb;
    logic clk_i = 0, reset_i = 1, prog = 0, ext_n = 1, tst_en = 0, mux_en = 0, rom_on = 0, slow = 0;
    logic [11:0] scan_drive = 12'h000, dout, dout_oe_n, ext_out, pin_out;
    logic [7:0] din, din_oe_n, ext_in, pin_in, m, flash_rdata, tst_hi = 8'h00, tst_mux = 8'h00, rom_byte;
    logic [2:0] tst_ctl = 3'b110;
    logic [19:0] flt = 20'h5_5555;
    logic [31:0] seed = 32'h0000_0011;
    logic [15:0] a, rom_addr;
    logic [7:0] d, sense;
    logic ctrl_reset_n, rom_en, got;
    int failures = 0, total_checks = 0, cycles = 0, rom_err;
    flash_port_pkg::fetch_req_s fetch_req = '0;
    flash_port_pkg::fetch_rsp_s fetch_rsp;
    flash_port_pkg::flash_req_s flash_req;
    flash_port_pkg::mode_e mode;
    // ----------------------------------------
    // pins: device drive wins, else memory model, tester, or a changing pattern
    // ----------------------------------------
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) flt <= ~flt;
    always_comb begin
        m = rom_en ? rom_byte : (mux_en ? tst_mux : flt[7:0]);
        for (int k = 0; k < 8; k++) ext_out[k] = tst_en ? tst_hi[7 - k] : flt[8 + k];
        for (int j = 0; j < 4; j++) begin
            ext_out[8 + j] = m[7 - j];
            ext_in[j] = m[3 - j];
        end
        ext_in[6:4] = tst_en ? tst_ctl : flt[18:16];
        ext_in[7] = flt[19];
    end
    assign pin_out = (dout & ~dout_oe_n) | (ext_out & dout_oe_n);
    assign pin_in = (din & ~din_oe_n) | (ext_in & din_oe_n);
    assign flash_rdata = flash_fn(flash_req.addr);
    flash_port_mode_mux u_dut (.clk_i(clk_i), .reset_i(reset_i), .tester_program_select_i(prog),
        .external_code_select_n_i(ext_n), .scan_out_pin_i(pin_out), .scan_out_pin_o(dout),
        .scan_out_pin_oe_n_o(dout_oe_n), .scan_in_pin_i(pin_in), .scan_in_pin_o(din),
        .scan_in_pin_oe_n_o(din_oe_n), .scan_drive_i(scan_drive), .scan_sense_o(sense),
        .flash_req_o(flash_req), .flash_rdata_i(flash_rdata), .fetch_req_i(fetch_req),
        .fetch_rsp_o(fetch_rsp), .ctrl_flash_addr_i(fetch_req.addr), .ctrl_reset_n_o(ctrl_reset_n),
        .mode_o(mode));
    ext_rom_model u_rom (.active_i(rom_on), .slow_i(slow), .pin_out_i(pin_out), .pin_in_i(pin_in),
        .drive_en_o(rom_en), .drive_o(rom_byte), .addr_o(rom_addr), .err_cnt_o(rom_err));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] flash_fn(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5A;
    endfunction
    function automatic logic [7:0] rom_fn(input logic [15:0] x);
        return x[15:8] + x[7:0] + 8'h33;
    endfunction
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tick();
        @(posedge clk_i);
        #10;
    endtask
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            summarize();
        end
    end
    // request held until the valid pulse is seen, then dropped
    task automatic fetch(input logic [15:0] x, input logic [7:0] exp);
        got = 0;
        fetch_req.addr = x;
        fetch_req.req = 1'b1;
        scan_drive = 12'(rnd());
        for (int i = 0; i < 20 && !got; i++) begin
            tick();
            if (rom_on && din_oe_n[6] === 1'b0 && din[6] === 1'b0) check(1'b0, "write strobe driven");
            if (fetch_rsp.valid === 1'b1) got = 1;
        end
        check(got === 1'b1 && fetch_rsp.data === exp, "fetched byte");
        if (mode === flash_port_pkg::MODE_NORMAL) begin
            check(dout === scan_drive && dout_oe_n === 12'h000 && sense === ~pin_in, "scan pins");
        end
        fetch_req.req = 1'b0;
        tick();
    endtask
    task automatic tester_cycle(input logic [15:0] x, input logic [7:0] v, input logic wr);
        tst_hi = x[15:8];
        tst_mux = x[7:0];
        mux_en = 1;
        tst_ctl = 3'b111;
        tick();
        tst_ctl = 3'b110;
        tick();
        tst_mux = v;
        mux_en = wr;
        tst_ctl = wr ? 3'b010 : 3'b100;
        repeat (2) tick();
        if (!wr) check(pin_in[5] === 1'b0 && {pin_out[8], pin_out[9], pin_out[10], pin_out[11], pin_in[0],
            pin_in[1], pin_in[2], pin_in[3]} === flash_fn(x) && flash_req.rd === 1'b1, "tester read");
        tst_ctl = 3'b110;
        got = 0;
        for (int i = 0; i < 4; i++) begin
            tick();
            if (flash_req.wr === 1'b1) got = flash_req.addr === x && flash_req.wdata === v;
        end
        if (wr) check(got, "tester write");
        else check(dout_oe_n[11:8] === 4'hF && din_oe_n[3:0] === 4'hF, "read release");
        mux_en = 0;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) tick();
        check(ctrl_reset_n === 1'b0 && din_oe_n === 8'hFF, "reset state");
        reset_i = 0;
        repeat (3) tick();
        check(ctrl_reset_n === 1'b1 && mode === flash_port_pkg::MODE_NORMAL, "normal run");
        for (int n = 0; n < 3; n++) begin
            a = 16'(rnd());
            fetch(a, flash_fn(a));
        end
        prog = 1;
        tst_en = 1;
        repeat (2) tick();
        check(mode === flash_port_pkg::MODE_TESTER && ctrl_reset_n === 1'b0, "tester entry");
        check(flash_req.wp_disable === 1'b1 && din_oe_n[6:4] === 3'b111 && dout_oe_n === 12'hfff,
            "tester pins");
        for (int n = 0; n < 6; n++) begin
            a = (n == 0) ? 16'hFFFF : 16'(rnd());
            d = 8'(rnd());
            tester_cycle(a, d, 1'b1);
            tester_cycle(a ^ 16'h0100, 8'h00, 1'b0);
        end
        check(ctrl_reset_n === 1'b0, "held in reset");
        prog = 0;
        got = 0;
        for (int i = 0; i < 4; i++) begin
            tick();
            if (flash_req.read_array === 1'b1) got = 1;
        end
        tst_en = 0;
        check(got, "array read on exit");
        check(ctrl_reset_n === 1'b1 && flash_req.wp_disable === 1'b0, "exit state");
        a = 16'(rnd());
        fetch(a, flash_fn(a));
        ext_n = 0;
        repeat (2) tick();
        rom_on = 1;
        check(mode === flash_port_pkg::MODE_EXTCODE && flash_req.reset === 1'b1, "ext entry");
        check(din_oe_n[5:4] === 2'b00 && dout_oe_n[7:0] === 8'h00, "ext pins");
        for (int n = 0; n < 6; n++) begin
            slow = n[0];
            a = (n == 5) ? 16'h0000 : 16'(rnd());
            fetch(a, rom_fn(a));
            check(rom_addr === a && flash_req.reset === 1'b1, "ext address");
        end
        check(rom_err === 0, "strobe order");
        rom_on = 0;
        ext_n = 1;
        repeat (2) tick();
        prog = 1;
        ext_n = 0;
        repeat (2) tick();
        check(mode === flash_port_pkg::MODE_NORMAL, "both selects");
        summarize();
    end
endmodule
